// [include/tlbd_pkg.sv]
// Package for the TLB entry readout decoder: register map, field
// positions, reserved-bit masks and encodings.
// Assumes a 32-bit AXI4-Lite register bus; each register one word.
package tlbd_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] TLBD_REG_SELECT = 8'h00;
   localparam logic [7:0] TLBD_REG_W0_LO  = 8'h04;
   localparam logic [7:0] TLBD_REG_W0_HI  = 8'h08;
   localparam logic [7:0] TLBD_REG_W1_LO  = 8'h0C;
   localparam logic [7:0] TLBD_REG_W1_HI  = 8'h10;
   localparam logic [7:0] TLBD_REG_W2_LO  = 8'h14;
   localparam logic [7:0] TLBD_REG_W2_HI  = 8'h18;
   localparam logic [7:0] TLBD_REG_STATUS = 8'h1C;
   localparam logic [7:0] TLBD_REG_VA_LO  = 8'h20;
   localparam logic [7:0] TLBD_REG_VA_HI  = 8'h24;

   // ----------------------------------------------------------------
   // Select register fields
   // ----------------------------------------------------------------
   localparam int TLBD_SEL_INDEX_LSB = 0;
   localparam int TLBD_SEL_WAY_LSB   = 8;
   localparam int TLBD_SEL_PAGE_LSB  = 12;
   localparam int TLBD_SEL_CAPTURE   = 16;

   // ----------------------------------------------------------------
   // Readout word fields
   // ----------------------------------------------------------------
   localparam int TLBD_W0_COALESCED = 6;
   localparam int TLBD_W0_VALID_LSB = 2;
   localparam int TLBD_W0_SIZE_LSB  = 17;
   localparam int TLBD_W0_ATTR_LSB  = 58;
   localparam int TLBD_W0_PASL_LSB  = 20;
   localparam int TLBD_W1_WALK      = 43;
   localparam int TLBD_W1_VA_TOP    = 42;

   localparam logic [3:0] TLBD_VALID_SINGLE = 4'h1;
   localparam logic [2:0] TLBD_ATTR_WB_RWA  = 3'h7;

   typedef enum logic [2:0] {
      TLBD_COAL_NONE = 3'b000,
      TLBD_COAL_4K   = 3'b001,
      TLBD_COAL_16K  = 3'b010,
      TLBD_COAL_64K  = 3'b011
   } tlbd_coal_e;

   // Reserved positions forced to zero
   localparam logic [63:0] TLBD_W0_MASK = 64'hDC3F_FFFF_FFFE_007C;
   localparam logic [63:0] TLBD_W1_MASK = 64'hFFFF_FFFF_FFFF_D001;
   localparam logic [63:0] TLBD_W2_MASK = 64'h0000_0000_0000_FFFF;

   // ----------------------------------------------------------------
   // Status register fields
   // ----------------------------------------------------------------
   localparam int TLBD_ST_COAL  = 0;
   localparam int TLBD_ST_VALID = 1;
   localparam int TLBD_ST_SIZE  = 5;
   localparam int TLBD_ST_WALK  = 8;
   localparam int TLBD_ST_EVAL  = 9;
   localparam int TLBD_ST_WBRWA = 10;
   localparam int TLBD_ST_PASL  = 11;
   localparam int TLBD_ST_VAOK  = 13;

   localparam logic [1:0] TLBD_RESP_OKAY   = 2'b00;
   localparam logic [1:0] TLBD_RESP_SLVERR = 2'b10;

endpackage

// [include/tlbd_dec_if.sv]
// Interface between the register block and the entry decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ns
interface tlbd_dec_if;
   logic [63:0] word0;
   logic [63:0] word1;
   logic [7:0]  index;
   logic [1:0]  page;
   logic        coalesced;
   logic [3:0]  valid_bits;
   logic [2:0]  size;
   logic        walk;
   logic        entry_valid;
   logic        wb_rwa;
   logic [1:0]  pa_slice;
   logic        va_ok;
   logic [36:0] va;

   modport owner (output word0, word1, index, page,
                  input coalesced, valid_bits, size, walk, entry_valid,
                  wb_rwa, pa_slice, va_ok, va);
   modport dec   (input word0, word1, index, page,
                  output coalesced, valid_bits, size, walk, entry_valid,
                  wb_rwa, pa_slice, va_ok, va);
endinterface // tlbd_dec_if

// [logic/tlbd_decode.sv]
// Combinational field decoder for one captured TLB entry.
// Assumes the words arrive already cleared at reserved positions.
`timescale 1ns/1ns
module tlbd_decode (
   tlbd_dec_if.dec d
);
   import tlbd_pkg::*;

   logic [2:0] sz;
   logic       coal;

   always_comb begin
      coal          = d.word0[TLBD_W0_COALESCED];
      sz            = d.word0[TLBD_W0_SIZE_LSB +: 3];
      d.coalesced   = coal;
      d.size        = sz;
      d.valid_bits  = d.word0[TLBD_W0_VALID_LSB +: 4];
      d.walk        = d.word1[TLBD_W1_WALK];
      d.wb_rwa      = d.word0[TLBD_W0_ATTR_LSB +: 3]
                      == TLBD_ATTR_WB_RWA;
      // Slice of the selected page, PA bits just above the page size
      d.pa_slice    = d.word0[TLBD_W0_PASL_LSB + 2 * d.page +: 2];
      if (coal)
         d.entry_valid = d.valid_bits[d.page];
      else
         d.entry_valid = d.valid_bits == TLBD_VALID_SINGLE;
      d.va_ok = 1'b1;
      if (!coal) begin
         d.va = {d.word1[TLBD_W1_VA_TOP:14], d.index};
      end else begin
         unique case (sz)
            TLBD_COAL_4K:
               d.va = {d.word1[TLBD_W1_VA_TOP:16], d.index, d.page};
            TLBD_COAL_16K:
               d.va = {d.word1[TLBD_W1_VA_TOP:18], d.index, d.page,
                       2'h0};
            TLBD_COAL_64K:
               d.va = {d.word1[TLBD_W1_VA_TOP:20], d.index, d.page,
                       4'h0};
            default: begin
               d.va    = '0;
               d.va_ok = 1'b0;
            end
         endcase
      end
      // Walk-cache entries carry a different layout: no VA or entry-valid decode
      if (d.walk) begin
         d.va          = '0;
         d.va_ok       = 1'b0;
         d.entry_valid = 1'b0;
      end
   end
endmodule // tlbd_decode

// [logic/tlbd_top.sv]
// TLB entry readout block: AXI4-Lite slave, entry select, capture of
// the three readout words and decoded entry status.
// Assumes the TLB RAM presents the selected entry on entry_word* in the
// same cycle that entry_sel_* change, on the same clock.
`timescale 1ns/1ns

module tlbd_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [2:0]       entry_sel_way,
   output logic [7:0]       entry_sel_index,
   output logic             entry_capture,
   input  wire logic [63:0] entry_word0,
   input  wire logic [63:0] entry_word1,
   input  wire logic [63:0] entry_word2
);
   import tlbd_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic        aw_have_q, aw_have_d;
   logic        w_have_q,  w_have_d;
   logic [7:0]  awaddr_q,  awaddr_d;
   logic [31:0] wdata_q,   wdata_d;
   logic [3:0]  wstrb_q,   wstrb_d;
   logic        bvalid_q,  bvalid_d;
   logic [1:0]  bresp_q,   bresp_d;
   logic        rvalid_q,  rvalid_d;
   logic [1:0]  rresp_q,   rresp_d;
   logic [31:0] rdata_q,   rdata_d;
   logic [7:0]  index_q,   index_d;
   logic [2:0]  way_q,     way_d;
   logic [1:0]  page_q,    page_d;
   logic        cap_q,     cap_d;
   logic [63:0] w0_q, w0_d;
   logic [63:0] w1_q, w1_d;
   logic [63:0] w2_q, w2_d;
   logic [31:0] status_q, status_d;
   logic [36:0] va_q, va_d;
   logic        awready_q, awready_d;
   logic        wready_q,  wready_d;
   logic        arready_q, arready_d;
   logic        do_write;

   tlbd_dec_if dif ();

   assign dif.word0 = w0_q;
   assign dif.word1 = w1_q;
   assign dif.index = index_q;
   assign dif.page  = page_q;

   tlbd_decode u_decode (
      .d (dif.dec)
   );

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i])
            r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction

   // Select register image; the capture bit always reads back as zero
   function automatic logic [31:0] sel_pack(input logic [1:0] pg,
                                            input logic [2:0] wy,
                                            input logic [7:0] ix);
      return {18'h0, pg, 1'b0, wy, ix};
   endfunction

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] sel;
      sel       = '0;
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      index_d   = index_q;
      way_d     = way_q;
      page_d    = page_q;
      cap_d     = 1'b0;
      w0_d      = w0_q;
      w1_d      = w1_q;
      w2_d      = w2_q;

      // Address and data are taken independently, in either order
      if (s_axi_awvalid && !aw_have_q) begin
         aw_have_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q) begin
         w_have_d = 1'b1;
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
      end

      do_write = aw_have_q && w_have_q && !bvalid_q;
      if (do_write) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = TLBD_RESP_OKAY;
         unique case ({awaddr_q[7:2], 2'b00})
            TLBD_REG_SELECT: begin
               sel     = merge(sel_pack(page_q, way_q, index_q),
                               wdata_q, wstrb_q);
               index_d = sel[TLBD_SEL_INDEX_LSB +: 8];
               way_d   = sel[TLBD_SEL_WAY_LSB +: 3];
               page_d  = sel[TLBD_SEL_PAGE_LSB +: 2];
               cap_d   = sel[TLBD_SEL_CAPTURE] && wstrb_q[2];
            end
            TLBD_REG_W0_LO, TLBD_REG_W0_HI, TLBD_REG_W1_LO,
            TLBD_REG_W1_HI, TLBD_REG_W2_LO, TLBD_REG_W2_HI,
            TLBD_REG_STATUS, TLBD_REG_VA_LO, TLBD_REG_VA_HI:
               bresp_d = TLBD_RESP_OKAY;
            default:
               bresp_d = TLBD_RESP_SLVERR;
         endcase
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end

      // Entry words are latched in the capture strobe cycle, on the edge that ends it
      if (cap_q) begin
         w0_d = entry_word0 & TLBD_W0_MASK;
         w1_d = entry_word1 & TLBD_W1_MASK;
         w2_d = entry_word2 & TLBD_W2_MASK;
      end

      if (rvalid_q) begin
         if (s_axi_rready)
            rvalid_d = 1'b0;
      end else if (s_axi_arvalid) begin
         rvalid_d = 1'b1;
         rresp_d  = TLBD_RESP_OKAY;
         unique case ({s_axi_araddr[7:2], 2'b00})
            TLBD_REG_SELECT:
               rdata_d = sel_pack(page_q, way_q, index_q);
            TLBD_REG_W0_LO:  rdata_d = w0_q[31:0];
            TLBD_REG_W0_HI:  rdata_d = w0_q[63:32];
            TLBD_REG_W1_LO:  rdata_d = w1_q[31:0];
            TLBD_REG_W1_HI:  rdata_d = w1_q[63:32];
            TLBD_REG_W2_LO:  rdata_d = w2_q[31:0];
            TLBD_REG_W2_HI:  rdata_d = w2_q[63:32];
            TLBD_REG_STATUS: rdata_d = status_q;
            TLBD_REG_VA_LO:  rdata_d = {va_q[19:0], 12'h000};
            TLBD_REG_VA_HI:  rdata_d = {15'h0, va_q[36:20]};
            default: begin
               rdata_d = '0;
               rresp_d = TLBD_RESP_SLVERR;
            end
         endcase
      end

      // Readies are registered copies of the next holding state
      awready_d = !aw_have_d;
      wready_d  = !w_have_d;
      arready_d = !rvalid_d;

      // Decode is registered so reads see a stable snapshot
      status_d = '0;
      status_d[TLBD_ST_COAL]       = dif.coalesced;
      status_d[TLBD_ST_VALID +: 4] = dif.valid_bits;
      status_d[TLBD_ST_SIZE +: 3]  = dif.size;
      status_d[TLBD_ST_WALK]       = dif.walk;
      status_d[TLBD_ST_EVAL]       = dif.entry_valid;
      status_d[TLBD_ST_WBRWA]      = dif.wb_rwa;
      status_d[TLBD_ST_PASL +: 2]  = dif.pa_slice;
      status_d[TLBD_ST_VAOK]       = dif.va_ok;
      va_d = dif.va;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= TLBD_RESP_OKAY;
         rvalid_q  <= 1'b0;
         rresp_q   <= TLBD_RESP_OKAY;
         rdata_q   <= '0;
         index_q   <= '0;
         way_q     <= '0;
         page_q    <= '0;
         cap_q     <= 1'b0;
         w0_q      <= '0;
         w1_q      <= '0;
         w2_q      <= '0;
         status_q  <= '0;
         va_q      <= '0;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         arready_q <= 1'b1;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
         index_q   <= index_d;
         way_q     <= way_d;
         page_q    <= page_d;
         cap_q     <= cap_d;
         w0_q      <= w0_d;
         w1_q      <= w1_d;
         w2_q      <= w2_d;
         status_q  <= status_d;
         va_q      <= va_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         arready_q <= arready_d;
      end
   end

   // Readies stand low while a captured address or data word waits
   // for its partner, or while a read answer is still pending.
   assign s_axi_awready   = awready_q;
   assign s_axi_wready    = wready_q;
   assign s_axi_arready   = arready_q;
   assign s_axi_bvalid    = bvalid_q;
   assign s_axi_bresp     = bresp_q;
   assign s_axi_rvalid    = rvalid_q;
   assign s_axi_rresp     = rresp_q;
   assign s_axi_rdata     = rdata_q;
   assign entry_sel_way   = way_q;
   assign entry_sel_index = index_q;
   assign entry_capture   = cap_q;

endmodule // tlbd_top

// [tb/tlbd_assertions.sv]
// Concurrent checks on the TLB entry readout block, bound to tlbd_top.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns
module tlbd_assertions
   import tlbd_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_bvalid,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        entry_capture,
   input wire logic [63:0] entry_word0,
   input wire logic [63:0] entry_word1
);
   // ---------------------------------------------------------------
   // Shadow of the captured entry
   // ---------------------------------------------------------------
   logic [63:0] w0_q;
   logic        walk_q;
   logic [2:0]  busy_q;
   logic        st_rd;

   // Status lags captures and select writes, so only settled reads count
   assign st_rd = s_axi_arvalid && s_axi_arready && busy_q == 3'h0
      && !entry_capture && !s_axi_bvalid
      && s_axi_araddr[7:2] == TLBD_REG_STATUS[7:2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w0_q <= 64'h0;
         walk_q <= 1'b0;
         busy_q <= 3'h0;
      end else begin
         busy_q <= {busy_q[1:0], entry_capture | s_axi_bvalid};
         if (entry_capture) begin
            w0_q <= entry_word0;
            walk_q <= entry_word1[43];
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer changed before it was taken");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer changed before it was taken");
   chk_capture_pulse: assert property (entry_capture |=> !entry_capture)
      else $error("capture strobe longer than one cycle");
   chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[7:2] > 6'h09 |=> s_axi_rresp == TLBD_RESP_SLVERR
      && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   chk_coal_flag: assert property (st_rd |=> s_axi_rdata[0] == w0_q[6])
      else $error("status coalesced flag wrong");
   chk_page_valid: assert property (st_rd |=>
      s_axi_rdata[4:1] == w0_q[5:2]) else $error("status valid bits wrong");
   chk_walk_block: assert property (st_rd && walk_q |=>
      s_axi_rdata[9] == 1'b0 && s_axi_rdata[13] == 1'b0)
      else $error("walk entry decoded as a page");
   chk_attr_code: assert property (st_rd |=>
      s_axi_rdata[10] == (w0_q[60:58] == TLBD_ATTR_WB_RWA))
      else $error("status attribute flag wrong");
   chk_reserved_zero: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[7:2] == TLBD_REG_W0_HI[7:2]
      |=> (s_axi_rdata & ~TLBD_W0_MASK[63:32]) == 32'h0)
      else $error("reserved word bits not zero");

   cover property (st_rd && w0_q[6]);
   cover property (st_rd && walk_q);
   cover property (s_axi_bvalid && s_axi_bresp == TLBD_RESP_SLVERR);
endmodule // tlbd_assertions

bind tlbd_top tlbd_assertions i_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bresp(s_axi_bresp), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .entry_capture(entry_capture),
   .entry_word0(entry_word0), .entry_word1(entry_word1)
);

// [tb/l2_tlb_entry_readout_decode_bench.sv]
// Self-checking bench for the TLB entry readout block.
// Assumes tlbd_pkg, tlbd_top and the bound checker are compiled first.
`timescale 1ns/1ns
module l2_tlb_entry_readout_decode_bench;
   import tlbd_pkg::*;
   typedef struct {string n; logic [33:0] v;} tlbd_exp_s;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic [63:0] entry_word0 = 64'h0, entry_word1 = 64'h0;
   logic [63:0] entry_word2 = 64'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, entry_capture;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [2:0]  entry_sel_way;
   logic [7:0]  entry_sel_index;
   int          failures = 0, check_count = 0;
   tlbd_exp_s   rq[$], bq[$], cq[$];

   always #50 aclk = ~aclk;

   tlbd_top i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .entry_sel_way(entry_sel_way),
      .entry_sel_index(entry_sel_index), .entry_capture(entry_capture),
      .entry_word0(entry_word0), .entry_word1(entry_word1),
      .entry_word2(entry_word2));

   // ---------------------------------------------------------------
   // Bus tasks and result monitor
   // ---------------------------------------------------------------
   task automatic chk(input tlbd_exp_s e, input logic [33:0] seen);
      check_count++;
      if (seen !== e.v) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", e.n, e.v, seen);
      end
   endtask

   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready)
         chk(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready)
         chk(bq.pop_front(), {32'h0, s_axi_bresp});
      if (entry_capture)
         chk(cq.pop_front(), {23'h0, entry_sel_way, entry_sel_index});
   end

   // Ready is sometimes raised late so that held answers get exercised
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] r);
      @(posedge aclk);
      bq.push_back('{"bresp", {32'h0, r}});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'($urandom);
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r, input string n);
      @(posedge aclk);
      rq.push_back('{n, {r, d}});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'($urandom);
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      if (!s_axi_rready) begin
         @(posedge aclk);
         s_axi_rready <= 1'b1;
      end
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask

   task automatic entry_case(input logic c, input logic [2:0] sz,
                             input logic [1:0] pg, input logic wk);
      logic [63:0]  w0, w1;
      logic [191:0] wv;
      logic [48:0]  va;
      logic [31:0]  st, sel;
      logic         ok;
      w0 = {$urandom, $urandom};
      w1 = {$urandom, $urandom};
      w0[6] = c;
      w0[19:17] = sz;
      w1[43] = wk;
      if (sz[0]) w0[5:2] = 4'h1;
      if (sz[1]) w0[60:58] = 3'h7;
      wv = {$urandom, $urandom, w1 & TLBD_W1_MASK, w0 & TLBD_W0_MASK};
      wv[191:128] = wv[191:128] & TLBD_W2_MASK;
      sel = {15'h0, 1'b1, 2'h0, pg, 1'b0, 3'($urandom), 8'($urandom)};
      entry_word0 <= w0;
      entry_word1 <= w1;
      entry_word2 <= {$urandom, $urandom} & ~TLBD_W2_MASK | wv[191:128];
      cq.push_back('{"entry_sel", {23'h0, sel[10:8], sel[7:0]}});
      wr(TLBD_REG_SELECT, sel, 4'hF, TLBD_RESP_OKAY);
      ok = !wk;
      va = '0;
      if (!c) va[48:12] = {w1[42:14], sel[7:0]};
      else if (sz == 3'h1) va[48:12] = {w1[42:16], sel[7:0], pg};
      else if (sz == 3'h2) va[48:14] = {w1[42:18], sel[7:0], pg};
      else if (sz == 3'h3) va[48:16] = {w1[42:20], sel[7:0], pg};
      else ok = 1'b0;
      if (!ok) va = '0;
      st = {18'h0, ok, w0[20 + 2 * pg +: 2], w0[60:58] == 3'h7,
            !wk && (c ? w0[2 + pg] : w0[5:2] == 4'h1), wk, sz, w0[5:2], c};
      rd(TLBD_REG_SELECT, sel & 32'h0000_37FF, TLBD_RESP_OKAY, "select");
      for (int i = 0; i < 6; i++)
         rd(TLBD_REG_W0_LO + 8'(4*i), wv[32*i +: 32], 2'h0, "word");
      rd(TLBD_REG_STATUS, st, 2'h0, "status");
      rd(TLBD_REG_VA_LO, {va[31:12], 12'h0}, 2'h0, "valo");
      rd(TLBD_REG_VA_HI, {15'h0, va[48:32]}, 2'h0, "va_hi");
   endtask

   task automatic finish_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Test sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'hF4CB4587));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(TLBD_REG_SELECT, 32'h0, TLBD_RESP_OKAY, "select_reset");
      wr(TLBD_REG_SELECT, 32'h0000_37FF, 4'h2, TLBD_RESP_OKAY);
      rd(TLBD_REG_SELECT, 32'h0000_3700, TLBD_RESP_OKAY, "select_lanes");
      wr(TLBD_REG_W0_LO, 32'hFFFF_FFFF, 4'hF, TLBD_RESP_OKAY);
      wr(8'h40, 32'h0000_0001, 4'hF, TLBD_RESP_SLVERR);
      rd(8'hFC, 32'h0, TLBD_RESP_SLVERR, "unmapped");
      $display("test bus_access done");
      for (int c = 0; c < 2; c++)
         for (int s = 0; s < 8; s++)
            entry_case(c[0], s[2:0], 2'($urandom), s == 5);
      $display("test size_codes done");
      for (int p = 0; p < 4; p++)
         entry_case(1'b1, 3'h1, p[1:0], 1'b0);
      $display("test coalesced_pages done");
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      $display("[FAIL] watchdog expected done seen timeout");
      finish_test();
   end
endmodule // l2_tlb_entry_readout_decode_bench
